// [rtl/rtc_device.sv]
// Clock device end: command port decode and both timekeeping variants.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module rtc_device
	import rtc_pkg::*;
(
	input  wire logic   i_clock,
	input  wire logic   i_srst,
	input  wire logic   i_variant_one,
	rtc_port_if.device  bus
);
	logic [7:0]  cmd;
	logic [7:0]  dport;
	logic [7:0]  hold;
	logic [7:0]  rdata;
	logic [1:0]  strap_sync;
	logic        v1;
	logic [25:0] xacc;
	logic        xtick;
	logic [14:0] tacc;
	logic        tick10k;
	logic [14:0] xcnt;
	logic        tick1hz;
	logic        ra_go;
	logic        wa_go;
	logic [4:0]  ra;
	logic [4:0]  wa;
	logic [7:0]  cnt [0:7];
	logic [7:0]  lat [0:7];
	logic [7:0]  next_cnt [0:7];
	logic [7:0]  wrap1;
	logic [7:0]  ien;
	logic [7:0]  st1;
	logic        eq1;
	logic        eq1_q;
	logic        armed;
	logic        chg;
	logic [7:0]  t2 [0:4];
	logic [7:0]  next_t2 [0:4];
	logic [3:0]  wrap2;
	logic [7:0]  al2 [0:2];
	logic [7:0]  ctl2;
	logic [7:0]  st2;
	logic        eq2_q;
	logic        sq_q;
	logic        sq;
	logic        per_ev;
	logic        alarm_ev;
	logic [7:0]  rd_mux;

	// BCD step with wrap; an out-of-range value written by software wraps too.
	function automatic logic [8:0] bcd_step(input logic [7:0] v,
		input logic [7:0] mx, input logic [7:0] mn);
		if (v >= mx)
			bcd_step = {1'b1, mn};
		else if (v[3:0] >= 4'h9)
			bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
		else
			bcd_step = {1'b0, v + 8'h01};
	endfunction : bcd_step

	// Days in a month given as BCD 1 to 12.
	function automatic logic [7:0] days_in(input logic [7:0] m,
		input logic leap);
		case (m)
			8'h02: days_in = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: days_in = 8'h30;
			default: days_in = 8'h31;
		endcase
	endfunction : days_in

	// The strap is a board pin, so it is synchronised before use. It is kept
	// out of reset so it has settled by the time the host probes it.
	always_ff @(posedge i_clock) begin
		strap_sync <= {strap_sync[0], i_variant_one};
	end
	assign v1 = strap_sync[1];

	// Crystal rate derived by phase accumulation from the bus clock.
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			xacc <= 26'h0;
			xtick <= 1'b0;
		end else if (xacc + 26'(XTAL_HZ) >= 26'(CLK_HZ)) begin
			xacc <= xacc + 26'(XTAL_HZ) - 26'(CLK_HZ);
			xtick <= 1'b1;
		end else begin
			xacc <= xacc + 26'(XTAL_HZ);
			xtick <= 1'b0;
		end
	end

	// Ten-thousandths tick divided from the crystal tick; restart realigns.
	always_ff @(posedge i_clock) begin
		if (i_srst || (wa_go && v1 && wa == A1_GO)) begin
			tacc <= 15'h0;
			tick10k <= 1'b0;
		end else if (xtick) begin
			tacc <= tacc + 15'(TENK_HZ);
			tick10k <= ({1'b0, tacc} + 16'(TENK_HZ)) >= 16'(XTAL_HZ);
		end else begin
			tick10k <= 1'b0;
		end
	end

	// Free crystal counter feeds the second map's seconds and rates.
	always_ff @(posedge i_clock) begin
		if (i_srst)
			xcnt <= 15'h0;
		else if (xtick)
			xcnt <= xcnt + 15'h1;
	end
	assign tick1hz = xtick && xcnt == 15'h7FFF;

	// A rising strobe bit in a command write starts the access.
	assign ra = bus.io_wdata[4:0];
	assign wa = cmd[4:0];
	assign ra_go = bus.io_wr && bus.io_addr == PORT_CMD &&
		bus.io_wdata[CMD_RSTB] && !cmd[CMD_RSTB];
	assign wa_go = bus.io_wr && bus.io_addr == PORT_CMD &&
		bus.io_wdata[CMD_WSTB] && !cmd[CMD_WSTB];

	// Command and data port storage.
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			cmd <= RST_BYTE;
			dport <= RST_BYTE;
		end else if (bus.io_wr && bus.io_addr == PORT_CMD) begin
			cmd <= bus.io_wdata;
		end else if (bus.io_wr && bus.io_addr == PORT_DATA) begin
			dport <= bus.io_wdata;
		end
	end

	// First map carry chain; day of month limit follows the month.
	always_comb begin
		logic       c;
		logic [8:0] s;
		logic [7:0] mx;
		logic [7:0] mon;
		c = tick10k && v1;
		s = bcd_step(cnt[7], 8'h99, 8'h00);
		// Month runs 0 to 11; one step up gives the 1 to 12 form that the
		// day table wants. Kept apart because the chain reuses s below.
		mon = s[7:0];
		mx = 8'h00;
		for (int i = 0; i < 8; i++) begin
			mx = (i == 6) ? days_in(mon, 1'b0) : MAX1[i];
			next_cnt[i] = cnt[i];
			wrap1[i] = 1'b0;
			if (c) begin
				s = bcd_step(cnt[i], mx, MIN1[i]);
				next_cnt[i] = s[7:0];
				wrap1[i] = s[8];
				c = s[8];
			end
		end
	end

	// First map counters and latches; software writes win over the tick.
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			for (int i = 0; i < 8; i++) begin
				cnt[i] <= RST_BYTE;
				lat[i] <= RST_BYTE;
			end
		end else begin
			for (int i = 0; i < 8; i++) begin
				cnt[i] <= next_cnt[i];
				if (wa_go && v1) begin
					if (wa == 5'(i))
						cnt[i] <= dport;
					if (wa == A1_LAT + 5'(i))
						lat[i] <= dport;
					if (wa == A1_CCLR && dport[i])
						cnt[i] <= RST_BYTE;
					if (wa == A1_LCLR && dport[i])
						lat[i] <= RST_BYTE;
					if (wa == A1_GO && i < 3)
						cnt[i] <= RST_BYTE;
				end
			end
		end
	end

	// Match is edge detected so one equality gives one event.
	always_comb begin
		eq1 = 1'b1;
		for (int i = 0; i < 8; i++)
			eq1 = eq1 && cnt[i] == lat[i];
	end

	// Interrupt enable, sticky status and read-consistency flag.
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			ien <= RST_BYTE;
			st1 <= RST_BYTE;
			eq1_q <= 1'b0;
			armed <= 1'b0;
			chg <= 1'b0;
		end else begin
			eq1_q <= eq1;
			if (wa_go && v1 && wa == A1_ICTL)
				ien <= dport;
			// Set wins over the clear-on-read so no event is lost.
			st1 <= (st1 & ~{8{ra_go && v1 && ra == A1_ISTAT}}) |
				({wrap1[7:1], eq1 && !eq1_q} & ien);
			if (ra_go && v1 && ra == A1_CHG) begin
				armed <= 1'b0;
				chg <= tick10k && armed;
			end else begin
				if (ra_go && v1 && ra < A1_ISTAT)
					armed <= 1'b1;
				if (tick10k && armed)
					chg <= 1'b1;
			end
		end
	end

	// Second map chain: seconds, minutes, hours, date, month.
	always_comb begin
		logic       c;
		logic       pm;
		logic [8:0] s;
		logic [7:0] h;
		c = tick1hz && !v1 && ctl2[C2_RUN];
		pm = t2[2][H_PM];
		s = 9'h0;
		h = {3'h0, t2[2][4:0]};
		for (int i = 0; i < 5; i++)
			next_t2[i] = t2[i];
		wrap2 = 4'h0;
		if (c) begin
			s = bcd_step(t2[0], 8'h59, 8'h00);
			next_t2[0] = s[7:0];
			wrap2[0] = s[8];
			c = s[8];
		end
		if (c) begin
			s = bcd_step(t2[1], 8'h59, 8'h00);
			next_t2[1] = s[7:0];
			wrap2[1] = s[8];
			c = s[8];
		end
		if (c) begin
			if (t2[2][H_12]) begin
				if (h == 8'h11) begin
					next_t2[2] = {!pm, 1'b1, 6'h12};
					c = pm;
				end else begin
					s = (h >= 8'h12) ? 9'h001 : bcd_step(h, 8'h12, 8'h01);
					next_t2[2] = {pm, 1'b1, s[5:0]};
					c = 1'b0;
				end
			end else begin
				s = bcd_step({2'h0, t2[2][5:0]}, 8'h23, 8'h00);
				next_t2[2] = {2'h0, s[5:0]};
				c = s[8];
			end
			wrap2[2] = c;
		end
		if (c) begin
			s = bcd_step(t2[3], days_in({1'b0, t2[4][6:0]}, t2[4][M_LEAP]),
				8'h01);
			next_t2[3] = s[7:0];
			wrap2[3] = s[8];
			c = s[8];
		end
		if (c) begin
			s = bcd_step({1'b0, t2[4][6:0]}, 8'h12, 8'h01);
			next_t2[4] = {t2[4][M_LEAP], s[6:0]};
		end
	end

	// Periodic source: square wave from the crystal counter or a boundary.
	always_comb begin
		logic [3:0] rs;
		rs = ctl2[7:4];
		sq = (rs >= 4'h1 && rs <= 4'hB) ? xcnt[rs + 4'h2] : 1'b0;
		unique case (rs)
			4'hC: per_ev = tick1hz && ctl2[C2_RUN];
			4'hD: per_ev = wrap2[0];
			4'hE: per_ev = wrap2[1];
			4'hF: per_ev = wrap2[2];
			default: per_ev = sq && !sq_q;
		endcase
	end
	assign alarm_ev = ctl2[C2_CLS] && !eq2_q && t2[0] == al2[0] &&
		t2[1] == al2[1] && t2[2] == al2[2];

	// Second map storage; counter/latch bit steers the writes.
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			for (int i = 0; i < 5; i++)
				t2[i] <= RST_BYTE;
			for (int i = 0; i < 3; i++)
				al2[i] <= RST_BYTE;
			ctl2 <= RST_BYTE;
			st2 <= RST_BYTE;
			eq2_q <= 1'b0;
			sq_q <= 1'b0;
		end else begin
			for (int i = 0; i < 5; i++)
				t2[i] <= next_t2[i];
			sq_q <= sq;
			eq2_q <= t2[0] == al2[0] && t2[1] == al2[1] && t2[2] == al2[2];
			if (wa_go && !v1) begin
				if (wa[2:0] == A2_CTL)
					ctl2 <= dport;
				else if (wa[2:0] >= A2_SEC && wa[2:0] <= A2_MON) begin
					if (!ctl2[C2_CLS])
						t2[wa[2:0] - A2_SEC] <= dport;
					else if (wa[2:0] <= A2_HOUR)
						al2[2'(wa[2:0] - A2_SEC)] <= dport;
				end
			end
			// Lower six status bits never set; set wins over clear-on-read.
			st2 <= (st2 & ~{8{ra_go && !v1 && ra[2:0] == A2_STAT}}) |
				{alarm_ev, per_ev, 6'h00};
		end
	end

	// Internal register read selection for both maps.
	always_comb begin
		rd_mux = 8'h00;
		if (v1) begin
			if (ra < A1_LAT)
				rd_mux = cnt[ra[2:0]];
			else if (ra < A1_ISTAT)
				rd_mux = lat[ra[2:0]];
			else if (ra == A1_ISTAT)
				rd_mux = st1;
			else if (ra == A1_CHG)
				rd_mux = {7'h00, chg};
		end else if (ra[2:0] >= A2_SEC && ra[2:0] <= A2_MON) begin
			rd_mux = t2[ra[2:0] - A2_SEC];
		end else if (ra[2:0] == A2_STAT) begin
			rd_mux = st2;
		end
	end

	// Read data captured at strobe rise and held for later port reads.
	always_ff @(posedge i_clock) begin
		if (i_srst)
			hold <= RST_BYTE;
		else if (ra_go)
			hold <= rd_mux;
	end

	// Port read answer one cycle after the read strobe; unmapped reads zero.
	always_ff @(posedge i_clock) begin
		if (i_srst)
			rdata <= RST_BYTE;
		else if (bus.io_rd && bus.io_addr == PORT_CMD)
			rdata <= hold;
		else if (bus.io_rd && bus.io_addr == PORT_STRAP)
			rdata <= {2'h0, v1, 5'h00};
		else
			rdata <= RST_BYTE;
	end
	assign bus.io_rdata = rdata;
	assign bus.clock_interrupt_line = v1 ? |st1 : |st2;
endmodule : rtc_device
`default_nettype wire

// [rtl/rtc_pkg.sv]
// Shared constants for the board clock access port and timekeeping.
package rtc_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int XTAL_HZ = 32768;
	localparam int TENK_HZ = 10000;
	localparam int STROBE_NS = 1000;
	localparam int STROBE_CYC = (STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int IOA_W = 10;
	localparam logic [9:0] PORT_DATA = 10'h05A;
	localparam logic [9:0] PORT_CMD = 10'h05C;
	localparam logic [9:0] PORT_STRAP = 10'h220;
	localparam int STRAP_BIT = 5;
	localparam int CMD_WSTB = 6;
	localparam int CMD_RSTB = 5;
	localparam logic [2:0] CODE_RADDR = 3'h4;
	localparam logic [2:0] CODE_RSTB = 3'h5;
	localparam logic [2:0] CODE_WADDR = 3'h0;
	localparam logic [2:0] CODE_WSTB = 3'h2;
	localparam logic [4:0] A1_LAT = 5'h08;
	localparam logic [4:0] A1_ISTAT = 5'h10;
	localparam logic [4:0] A1_ICTL = 5'h11;
	localparam logic [4:0] A1_CCLR = 5'h12;
	localparam logic [4:0] A1_LCLR = 5'h13;
	localparam logic [4:0] A1_CHG = 5'h14;
	localparam logic [4:0] A1_GO = 5'h15;
	localparam logic [2:0] A2_CTL = 3'h1;
	localparam logic [2:0] A2_SEC = 3'h2;
	localparam logic [2:0] A2_HOUR = 3'h4;
	localparam logic [2:0] A2_MON = 3'h6;
	localparam logic [2:0] A2_STAT = 3'h7;
	localparam int C2_RUN = 2;
	localparam int C2_CLS = 3;
	localparam int ST2_ALARM = 7;
	localparam int ST2_PER = 6;
	localparam int H_PM = 7;
	localparam int H_12 = 6;
	localparam int M_LEAP = 7;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] MAX1 [0:7] = '{8'h99, 8'h99, 8'h59, 8'h59,
		8'h23, 8'h07, 8'h31, 8'h11};
	localparam logic [7:0] MIN1 [0:7] = '{8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h01, 8'h01, 8'h00};
endpackage : rtc_pkg

// [rtl/rtc_port_if.sv]
// Byte-wide I/O port connection between host and clock device.
`timescale 1ns/1ps
`default_nettype none
interface rtc_port_if (input wire logic i_clock);
	logic [9:0] io_addr;
	logic       io_wr;
	logic       io_rd;
	logic [7:0] io_wdata;
	logic [7:0] io_rdata;
	logic       clock_interrupt_line;
	modport host (input i_clock, output io_addr, io_wr, io_rd, io_wdata,
		input io_rdata, clock_interrupt_line);
	modport device (input i_clock, input io_addr, io_wr, io_rd, io_wdata,
		output io_rdata, clock_interrupt_line);
endinterface : rtc_port_if
`default_nettype wire

// [rtl/rtc_host.sv]
// Host end: runs the slow clock access sequences for a simple user port.
`timescale 1ns/1ps
`default_nettype none
module rtc_host
	import rtc_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic       i_srst,
	rtc_port_if.host        bus,
	input  wire logic       i_req,
	input  wire logic       i_req_write,
	input  wire logic [4:0] i_req_addr,
	input  wire logic [7:0] i_req_data,
	output logic            o_busy,
	output logic            o_done,
	output logic [7:0]      o_rdata,
	output logic            o_variant_one,
	output logic            o_irq
);
	typedef enum {S_PROBE, S_PROBE_W, S_IDLE, S_ADDR, S_DATA, S_STB,
		S_WAIT, S_READ, S_RCAP, S_END} state_t;
	state_t     state;
	logic       wr_op;
	logic [4:0] addr;
	logic [7:0] data;
	logic [5:0] wcnt;

	// Sequence state; the strap is probed once before any access.
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			state <= S_PROBE;
			wr_op <= 1'b0;
			addr <= 5'h00;
			data <= 8'h00;
			wcnt <= 6'h00;
			o_done <= 1'b0;
			o_rdata <= 8'h00;
			o_variant_one <= 1'b0;
		end else begin
			o_done <= 1'b0;
			unique case (state)
				S_PROBE: state <= S_PROBE_W;
				S_PROBE_W: begin
					o_variant_one <= bus.io_rdata[STRAP_BIT];
					state <= S_IDLE;
				end
				S_IDLE: begin
					if (i_req) begin
						wr_op <= i_req_write;
						addr <= i_req_addr;
						data <= i_req_data;
						state <= S_ADDR;
					end
				end
				S_ADDR: state <= wr_op ? S_DATA : S_STB;
				S_DATA: state <= S_STB;
				S_STB: begin
					wcnt <= 6'h00;
					state <= S_WAIT;
				end
				S_WAIT: begin
					// Slow part: strobe stays up for the full settle time.
					wcnt <= wcnt + 6'h01;
					if (wcnt == 6'(STROBE_CYC - 1))
						state <= wr_op ? S_END : S_READ;
				end
				S_READ: state <= S_RCAP;
				S_RCAP: begin
					o_rdata <= bus.io_rdata;
					state <= S_END;
				end
				S_END: begin
					o_done <= 1'b1;
					state <= S_IDLE;
				end
			endcase
		end
	end

	// Port signals decoded from the state; one access per state.
	always_comb begin
		bus.io_wr = 1'b0;
		bus.io_rd = 1'b0;
		bus.io_addr = PORT_CMD;
		bus.io_wdata = 8'h00;
		unique case (state)
			S_PROBE: begin
				bus.io_rd = 1'b1;
				bus.io_addr = PORT_STRAP;
			end
			S_ADDR, S_END: begin
				bus.io_wr = 1'b1;
				bus.io_wdata = {wr_op ? CODE_WADDR : CODE_RADDR, addr};
			end
			S_DATA: begin
				bus.io_wr = 1'b1;
				bus.io_addr = PORT_DATA;
				bus.io_wdata = data;
			end
			S_STB: begin
				bus.io_wr = 1'b1;
				bus.io_wdata = {wr_op ? CODE_WSTB : CODE_RSTB, addr};
			end
			S_READ: bus.io_rd = 1'b1;
			default: begin
			end
		endcase
	end

	// Interrupt line re-registered for the user side.
	always_ff @(posedge i_clock) begin
		if (i_srst)
			o_irq <= 1'b0;
		else
			o_irq <= bus.clock_interrupt_line;
	end
	assign o_busy = state != S_IDLE;
endmodule : rtc_host
`default_nettype wire

// [tb/rtc_port_sva.sv]
// Protocol checker for the byte-wide port between the host and clock ends.
`timescale 1ns/1ps
`default_nettype none
module rtc_port_sva
	import rtc_pkg::*;
(
	input wire logic       i_clock,
	input wire logic       i_srst,
	input wire logic       i_variant_one,
	input wire logic [9:0] io_addr,
	input wire logic       io_wr,
	input wire logic       io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic       clock_interrupt_line
);
	logic cmd_wr;
	logic rstb;
	logic wstb;

	// Command port writes, split by the strobe code in the top three bits.
	assign cmd_wr = io_wr && (io_addr == PORT_CMD);
	assign rstb   = cmd_wr && (io_wdata[7:5] == CODE_RSTB);
	assign wstb   = cmd_wr && (io_wdata[7:5] == CODE_WSTB);

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_srst);

	// Read data may only be seen in the single answer cycle.
	rd_idle_zero_a: assert property (!io_rd |=> io_rdata == 8'h00)
		else $error("read data not zero outside answer cycle");
	strobe_excl_a: assert property (!(io_wr && io_rd))
		else $error("read and write strobes together");
	rstb_after_addr_a: assert property (rstb |->
		$past(cmd_wr) && $past(io_wdata) == {CODE_RADDR, io_wdata[4:0]})
		else $error("read strobe without address phase");
	rstb_wait_a: assert property (rstb |->
		##51 (io_rd && io_addr == PORT_CMD))
		else $error("command port not read after strobe wait");
	rstb_quiet_a: assert property (rstb |=> !cmd_wr [*8])
		else $error("read strobe disturbed while data settles");
	read_drop_a: assert property (io_rd && io_addr == PORT_CMD |->
		##2 (cmd_wr && io_wdata[7:5] == CODE_RADDR))
		else $error("read strobe not removed after read");
	wstb_after_data_a: assert property (wstb |->
		$past(io_wr) && $past(io_addr) == PORT_DATA)
		else $error("write strobe not preceded by data byte");
	wstb_drop_a: assert property (wstb |-> ##51
		(cmd_wr && io_wdata == {CODE_WADDR, $past(io_wdata[4:0], 51)}))
		else $error("write strobe not removed after wait");
	strap_read_a: assert property (io_rd && io_addr == PORT_STRAP |=>
		io_rdata[STRAP_BIT] == i_variant_one)
		else $error("strap bit does not match fitted variant");
endmodule : rtc_port_sva
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench joining the host and clock ends over the port.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import rtc_pkg::*;
;
	logic       i_clock;
	logic       i_srst;
	logic       i_variant_one;
	logic       i_req;
	logic       i_req_write;
	logic [4:0] i_req_addr;
	logic [7:0] i_req_data;
	logic       o_busy;
	logic       o_done;
	logic [7:0] o_rdata;
	logic       o_variant_one;
	logic       o_irq;
	logic [7:0] lat [0:7];
	int         mismatches;
	int         checked;
	int         seed;
	int         n;

	rtc_port_if bus (.i_clock(i_clock));

	rtc_host u_rtc_host (.i_clock(i_clock), .i_srst(i_srst), .bus(bus),
		.i_req(i_req), .i_req_write(i_req_write), .i_req_addr(i_req_addr),
		.i_req_data(i_req_data), .o_busy(o_busy), .o_done(o_done),
		.o_rdata(o_rdata), .o_variant_one(o_variant_one), .o_irq(o_irq));

	rtc_device u_rtc_device (.i_clock(i_clock), .i_srst(i_srst),
		.i_variant_one(i_variant_one), .bus(bus));

	rtc_port_sva u_rtc_port_sva (.i_clock(i_clock), .i_srst(i_srst),
		.i_variant_one(i_variant_one), .io_addr(bus.io_addr),
		.io_wr(bus.io_wr), .io_rd(bus.io_rd), .io_wdata(bus.io_wdata),
		.io_rdata(bus.io_rdata),
		.clock_interrupt_line(bus.clock_interrupt_line));

	// Free-running 50 MHz clock.
	always #10 i_clock = ~i_clock;

	// Random legal BCD byte no larger than the given BCD limit.
	function automatic logic [7:0] bcd_rand(input logic [7:0] lim);
		int v;
		v = ($random(seed) & 32'h7FFF) % (lim[7:4] * 10 + lim[3:0] + 1);
		return {4'(v / 10), 4'(v % 10)};
	endfunction : bcd_rand

	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
			mismatches++;
		end
	endtask : check

	// One user request; the wait is bounded so a lost done cannot hang us.
	task automatic op(input logic w, input logic [4:0] a, input logic [7:0] d);
		int k;
		@(posedge i_clock);
		i_req       <= 1'b1;
		i_req_write <= w;
		i_req_addr  <= a;
		i_req_data  <= d;
		@(posedge i_clock);
		i_req <= 1'b0;
		k = 0;
		while (o_done !== 1'b1 && k < 200) begin
			@(negedge i_clock);
			k++;
		end
		if (k >= 200) begin
			$display("unexpected done: expected 1, seen timeout");
			mismatches++;
		end
	endtask : op

	task automatic rd(input logic [4:0] a, input string what,
		input logic [7:0] exp);
		op(1'b0, a, 8'h00);
		check(what, exp, o_rdata);
	endtask : rd

	// Reset is held six cycles so the strap synchroniser settles first.
	task automatic do_reset(input logic v);
		int k;
		@(posedge i_clock);
		i_srst        <= 1'b1;
		i_variant_one <= v;
		repeat (6) @(posedge i_clock);
		i_srst <= 1'b0;
		k = 0;
		@(negedge i_clock);
		while (o_busy !== 1'b0 && k < 100) begin
			@(negedge i_clock);
			k++;
		end
		check("busy after probe", 8'h00, {7'h00, o_busy});
	endtask : do_reset

	task automatic summarize();
		$display("checks made %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize

	// Watchdog sized well above the longest expected run.
	initial begin
		repeat (95000) @(posedge i_clock);
		$display("unexpected run length: expected finish, seen timeout");
		mismatches++;
		summarize();
	end

	initial begin
		i_clock = 1'b0;
		i_srst = 1'b1;
		i_variant_one = 1'b1;
		i_req = 1'b0;
		i_req_write = 1'b0;
		i_req_addr = 5'h00;
		i_req_data = 8'h00;
		mismatches = 0;
		checked = 0;
		seed = 32'h8D42;
		do_reset(1'b1);
		check("variant", 8'h01, {7'h00, o_variant_one});
		for (int i = 0; i < 8; i++) begin
			lat[i] = bcd_rand(MAX1[i]);
			op(1'b1, A1_LAT + 5'(i), lat[i]);
		end
		for (int i = 0; i < 8; i++) begin
			rd(A1_LAT + 5'(i), "latch", lat[i]);
		end
		// One-hot clears must touch only the chosen byte.
		for (int i = 0; i < 8; i++) begin
			op(1'b1, A1_LCLR, 8'h01 << i);
			lat[i] = 8'h00;
			rd(A1_LAT + 5'(i), "latch clear", 8'h00);
			rd(A1_LAT + 5'((i + 1) % 8), "latch kept", lat[(i + 1) % 8]);
		end
		op(1'b1, 5'h04, 8'h15);
		op(1'b1, A1_CCLR, 8'h10);
		rd(5'h04, "hours clear", 8'h00);
		op(1'b1, 5'h03, 8'h42);
		rd(5'h03, "minutes", 8'h42);
		op(1'b1, 5'h03, 8'h00);
		rd(5'h03, "minutes zero", 8'h00);
		op(1'b1, 5'h02, 8'h37);
		// All latches are zero now, so the restart makes counter equal latch.
		op(1'b1, A1_ICTL, 8'h01);
		op(1'b1, A1_GO, 8'h00);
		rd(5'h02, "seconds restart", 8'h00);
		rd(5'h00, "fraction restart", 8'h00);
		check("match irq", 8'h01, {7'h00, o_irq});
		rd(A1_ISTAT, "match status", 8'h01);
		check("match irq clear", 8'h00, {7'h00, o_irq});
		// Well past the first ten-thousandth tick, so the counters must move.
		repeat (8000) @(posedge i_clock);
		op(1'b0, A1_CHG, 8'h00);
		check("change flag", 8'h01, o_rdata & 8'h01);
		op(1'b0, A1_CHG, 8'h00);
		check("change flag clear", 8'h00, o_rdata & 8'h01);
		$display("test first_map done");
		do_reset(1'b0);
		check("variant", 8'h00, {7'h00, o_variant_one});
		op(1'b1, {2'b00, A2_CTL}, 8'h00);
		op(1'b1, {2'b00, A2_SEC}, 8'h59);
		op(1'b1, {2'b00, A2_HOUR}, 8'h52);
		op(1'b1, {2'b00, A2_MON}, 8'h82);
		op(1'b1, {2'b00, A2_CTL}, 8'h08);
		op(1'b1, {2'b00, A2_SEC}, 8'h33);
		op(1'b1, {2'b00, A2_CTL}, 8'h00);
		rd({2'b00, A2_SEC}, "seconds", 8'h59);
		rd({2'b11, A2_SEC}, "seconds alias", 8'h59);
		rd({2'b00, A2_HOUR}, "hours", 8'h52);
		rd({2'b00, A2_MON}, "month", 8'h82);
		op(1'b1, {2'b00, A2_CTL}, 8'h14);
		n = 0;
		while (o_irq !== 1'b1 && n < 30000) begin
			@(negedge i_clock);
			n++;
		end
		check("periodic irq", 8'h01, {7'h00, o_irq});
		rd({2'b00, A2_STAT}, "int status", 8'h40);
		check("irq after read", 8'h00, {7'h00, o_irq});
		op(1'b1, {2'b00, A2_CTL}, 8'h04);
		op(1'b0, {2'b00, A2_STAT}, 8'h00);
		// Longer than one period of the fastest rate.
		repeat (26000) @(negedge i_clock);
		check("irq disabled", 8'h00, {7'h00, o_irq});
		// Alarm latches loaded with the halted time must match at once.
		op(1'b1, {2'b00, A2_CTL}, 8'h08);
		op(1'b1, {2'b00, A2_SEC}, 8'h59);
		op(1'b1, {2'b00, A2_HOUR}, 8'h52);
		check("alarm irq", 8'h01, {7'h00, o_irq});
		rd({2'b00, A2_STAT}, "alarm status", 8'h80);
		check("alarm irq clear", 8'h00, {7'h00, o_irq});
		$display("test second_map done");
		summarize();
	end
endmodule : tb_top
`default_nettype wire
